// file: src/bwc_consts.vh
// Behaviour
// (R01) prefetch window base bits 63:32, 32-bit read-write, resets to zero
// (R02) prefetch window limit bits 63:32, 32-bit read-write, resets to zero
// (R03) io upper word bits 15:0 hold io base address 31:16, reset zero
// (R04) io upper word bits 31:16 hold io limit address 31:16, reset zero
// (R05) capability pointer is read-only and returns 40h
// (R06) interrupt line byte stores software value, resets to zero
// (R07) interrupt pin byte read-only, resets to zero
// (R08) downstream ports: pin default overwritable by sideband or eeprom load
// (R09) control bit 16: poisoned packets ignored when 0, reported when 1
// (R10) control bit 17 gates secondary-to-primary error message forwarding
// (R11) bit 18 clear: every io address inside window forwarded downstream
// (R12) bit 18 set: first-64KB window hits in top 768 bytes of 1KB go upstream
// (R13) control bit 19 enables forwarding of vga memory and io ranges
// (R14) vga memory range is 000a0000h to 000bffffh inclusive
// (R15) vga io: first 64KB, low ten bits 3b0h-3bbh or 3c0h-3dfh
// (R16) prefetch limit compare uses low twenty bits all ones
// (R17) control bit 20: clear compares ten io bits, set compares sixteen
// (R18) inside window means base <= address <= limit, full width
`ifndef BWC_CONSTS_VH
`define BWC_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define BWC_OFF_PF_BASE_HI  8'h28
`define BWC_OFF_PF_LIMIT_HI 8'h2c
`define BWC_OFF_IO_HI       8'h30
`define BWC_OFF_CAP_PTR     8'h34
`define BWC_OFF_INT_CTRL    8'h3c

// ----------------------------------------
// reset and fixed values
// ----------------------------------------
`define BWC_RST_32          32'h0000_0000
`define BWC_RST_16          16'h0000
`define BWC_RST_8           8'h00
`define BWC_RST_CTRL        5'h00
`define BWC_CAP_PTR_VAL     8'h40
`define BWC_ZERO_WORD       32'h0000_0000

// ----------------------------------------
// bridge control bit positions in word 3ch
// ----------------------------------------
`define BWC_BIT_POISON      16
`define BWC_BIT_ERR_FWD     17
`define BWC_BIT_ISA         18
`define BWC_BIT_VGA         19
`define BWC_BIT_VGA16       20
`define BWC_CTRL_LSB        16
`define BWC_CTRL_MSB        20

// ----------------------------------------
// address constants
// ----------------------------------------
`define BWC_LOW20_ZERO      20'h00000
`define BWC_LOW20_ONES      20'hfffff
`define BWC_IO_LOW12_ZERO   12'h000
`define BWC_IO_LOW12_ONES   12'hfff
`define BWC_VGA_MEM_LO      64'h0000_0000_000a_0000
`define BWC_VGA_MEM_HI      64'h0000_0000_000b_ffff
`define BWC_VGA_IO_A_LO     10'h3b0
`define BWC_VGA_IO_A_HI     10'h3bb
`define BWC_VGA_IO_B_LO     10'h3c0
`define BWC_VGA_IO_B_HI     10'h3df
`define BWC_ISA_LOW_QTR     2'h0
`define BWC_VGA16_HI_ZERO   6'h00

`endif

// file: src/bwc_top.v
`timescale 1ns/100ps
`include "bwc_consts.vh"

// ----------------------------------------
// inclusive range compare
// ----------------------------------------
// purely combinational; callers register whatever depends on it
module bwc_range_cmp #(
  parameter WIDTH = 64
) (
  // value and bounds
  input  wire [WIDTH-1:0] value,
  input  wire [WIDTH-1:0] low,
  input  wire [WIDTH-1:0] high,
  // result
  output wire             in_range
);

// both ends inclusive, so an all-ones limit still matches
assign in_range = (value >= low) && (value <= high); // [R18]

endmodule

module bwc_top #(
  parameter DOWNSTREAM = 1
) (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // lower window fields from the rest of the header
  input  wire [11:0] pf_base_low,
  input  wire [11:0] pf_limit_low,
  input  wire [3:0]  io_base_low,
  input  wire [3:0]  io_limit_low,
  // interrupt pin default loading
  input  wire        sideband_pin_we,
  input  wire [7:0]  sideband_pin_data,
  input  wire        eeprom_pin_we,
  input  wire [7:0]  eeprom_pin_data,
  // request to classify
  input  wire        req_valid,
  input  wire        req_is_io,
  input  wire [63:0] req_addr,
  // secondary side events
  input  wire        sec_poison_seen,
  input  wire        sec_error_msg,
  // forwarding decisions
  output reg         decide_valid,
  output reg         prefetch_hit,
  output reg         io_forward_down,
  output reg         io_forward_up,
  output reg         vga_forward,
  output reg         poison_report,
  output reg         error_msg_forward,
  // control levels for the forwarding logic
  output reg         poison_response_enable,
  output reg         secondary_error_forward_enable,
  output reg         isa_enable,
  output reg         vga_enable,
  output reg         vga_16bit_decode,
  output reg  [7:0]  interrupt_pin
);

// ----------------------------------------
// register storage
// ----------------------------------------
reg  [31:0] prefetch_window_base_high;
reg  [31:0] prefetch_window_limit_high;
reg  [15:0] io_window_base_high;
reg  [15:0] io_window_limit_high;
reg  [7:0]  interrupt_line_byte;
reg  [7:0]  interrupt_pin_byte;
reg  [4:0]  bridge_control_bits;

wire        hit_pf_base;
wire        hit_pf_limit;
wire        hit_io;
wire        hit_cap;
wire        hit_ctrl;

// any other word ignores writes and reads back zero
assign hit_pf_base  = (reg_addr == `BWC_OFF_PF_BASE_HI);
assign hit_pf_limit = (reg_addr == `BWC_OFF_PF_LIMIT_HI);
assign hit_io       = (reg_addr == `BWC_OFF_IO_HI);
assign hit_cap      = (reg_addr == `BWC_OFF_CAP_PTR);
assign hit_ctrl     = (reg_addr == `BWC_OFF_INT_CTRL);

// ----------------------------------------
// register writes
// ----------------------------------------
always @(posedge clock or posedge rst) begin
  if (rst) begin
    prefetch_window_base_high  <= `BWC_RST_32; // [R01]
    prefetch_window_limit_high <= `BWC_RST_32; // [R02]
    io_window_base_high        <= `BWC_RST_16; // [R03]
    io_window_limit_high       <= `BWC_RST_16; // [R04]
    interrupt_line_byte        <= `BWC_RST_8;  // [R06]
    bridge_control_bits        <= `BWC_RST_CTRL;
  end else if (reg_wr) begin
    if (hit_pf_base) begin
      prefetch_window_base_high <= reg_wdata; // [R01]
    end else if (hit_pf_limit) begin
      prefetch_window_limit_high <= reg_wdata; // [R02]
    end else if (hit_io) begin
      io_window_base_high  <= reg_wdata[15:0]; // [R03]
      io_window_limit_high <= reg_wdata[31:16]; // [R04]
    end else if (hit_ctrl) begin
      interrupt_line_byte <= reg_wdata[7:0]; // [R06]
      // pin byte is read-only from software
      bridge_control_bits <= reg_wdata[`BWC_CTRL_MSB:`BWC_CTRL_LSB];
    end
  end
end

// ----------------------------------------
// interrupt pin default
// ----------------------------------------
// sideband write wins over eeprom load in the same cycle
always @(posedge clock or posedge rst) begin
  if (rst) begin
    interrupt_pin_byte <= `BWC_RST_8; // [R07]
  end else if (DOWNSTREAM != 0) begin
    if (sideband_pin_we) begin
      interrupt_pin_byte <= sideband_pin_data; // [R08]
    end else if (eeprom_pin_we) begin
      interrupt_pin_byte <= eeprom_pin_data; // [R08]
    end
  end
end

// ----------------------------------------
// register reads
// ----------------------------------------
reg  [31:0] next_rdata;

always @* begin
  next_rdata = `BWC_ZERO_WORD;
  if (hit_pf_base) begin
    next_rdata = prefetch_window_base_high;
  end else if (hit_pf_limit) begin
    next_rdata = prefetch_window_limit_high;
  end else if (hit_io) begin
    next_rdata = {io_window_limit_high, io_window_base_high};
  end else if (hit_cap) begin
    next_rdata = {24'h000000, `BWC_CAP_PTR_VAL}; // [R05]
  end else if (hit_ctrl) begin
    // unimplemented control bits above 20 read as zero
    next_rdata = {11'h000, bridge_control_bits,
                  interrupt_pin_byte, interrupt_line_byte}; // [R07]
  end
end

// data only in the cycle after the strobe, zero otherwise
always @(posedge clock or posedge rst) begin
  if (rst) begin
    reg_rdata <= `BWC_ZERO_WORD;
  end else if (reg_rd) begin
    reg_rdata <= next_rdata;
  end else begin
    reg_rdata <= `BWC_ZERO_WORD;
  end
end

// ----------------------------------------
// control field split
// ----------------------------------------
wire        ctl_poison;
wire        ctl_err_fwd;
wire        ctl_isa;
wire        ctl_vga;
wire        ctl_vga16;

assign ctl_poison  = bridge_control_bits[`BWC_BIT_POISON - `BWC_CTRL_LSB];
assign ctl_err_fwd = bridge_control_bits[`BWC_BIT_ERR_FWD - `BWC_CTRL_LSB];
assign ctl_isa     = bridge_control_bits[`BWC_BIT_ISA - `BWC_CTRL_LSB];
assign ctl_vga     = bridge_control_bits[`BWC_BIT_VGA - `BWC_CTRL_LSB];
assign ctl_vga16   = bridge_control_bits[`BWC_BIT_VGA16 - `BWC_CTRL_LSB];

// ----------------------------------------
// full window bounds
// ----------------------------------------
wire [63:0] pf_base_full;
wire [63:0] pf_limit_full;
wire [31:0] io_base_full;
wire [31:0] io_limit_full;

assign pf_base_full  = {prefetch_window_base_high, pf_base_low,
                        `BWC_LOW20_ZERO};
// limit always ends on a 1MB boundary
assign pf_limit_full = {prefetch_window_limit_high, pf_limit_low,
                        `BWC_LOW20_ONES}; // [R16]
assign io_base_full  = {io_window_base_high, io_base_low,
                        `BWC_IO_LOW12_ZERO}; // [R03]
assign io_limit_full = {io_window_limit_high, io_limit_low,
                        `BWC_IO_LOW12_ONES}; // [R04]

// ----------------------------------------
// window compares
// ----------------------------------------
wire        io_addr_fits;
wire        pf_in_win;
wire        io_low_in_win;
wire        io_in_win;

// an io address above 32 bits never matches the io window
assign io_addr_fits = (req_addr[63:32] == `BWC_ZERO_WORD);

// prefetchable window, full 64-bit compare
bwc_range_cmp #(
  .WIDTH(64)
) u_pf_win (
  .value    (req_addr),
  .low      (pf_base_full),
  .high     (pf_limit_full),
  .in_range (pf_in_win)
); // [R18]

// io window, low 32 bits only
bwc_range_cmp #(
  .WIDTH(32)
) u_io_win (
  .value    (req_addr[31:0]),
  .low      (io_base_full),
  .high     (io_limit_full),
  .in_range (io_low_in_win)
);

assign io_in_win = io_addr_fits && io_low_in_win; // [R18]

// ----------------------------------------
// isa restriction
// ----------------------------------------
wire        io_first_64k;
wire        io_top_768;
wire        isa_up;

// outside the first 64KB the restriction never applies
assign io_first_64k = io_addr_fits &&
                      (req_addr[31:16] == `BWC_RST_16);
// top 768 bytes of a 1KB block: bits 9:8 not both zero
assign io_top_768   = (req_addr[9:8] != `BWC_ISA_LOW_QTR);
assign isa_up       = ctl_isa && io_in_win &&
                      io_first_64k && io_top_768; // [R12]

// ----------------------------------------
// vga ranges
// ----------------------------------------
wire        vga_mem_hit;
wire        vga_io_mono;
wire        vga_io_color;
wire        vga_io_low10;
wire        vga_io_hit;

// legacy frame buffer
bwc_range_cmp #(
  .WIDTH(64)
) u_vga_mem (
  .value    (req_addr),
  .low      (`BWC_VGA_MEM_LO),
  .high     (`BWC_VGA_MEM_HI),
  .in_range (vga_mem_hit)
); // [R14]

// first io block of the adapter
bwc_range_cmp #(
  .WIDTH(10)
) u_vga_io_a (
  .value    (req_addr[9:0]),
  .low      (`BWC_VGA_IO_A_LO),
  .high     (`BWC_VGA_IO_A_HI),
  .in_range (vga_io_mono)
); // [R15]

// second io block of the adapter
bwc_range_cmp #(
  .WIDTH(10)
) u_vga_io_b (
  .value    (req_addr[9:0]),
  .low      (`BWC_VGA_IO_B_LO),
  .high     (`BWC_VGA_IO_B_HI),
  .in_range (vga_io_color)
); // [R15]

// upper io bits are judged separately through io_first_64k
assign vga_io_low10 = vga_io_mono || vga_io_color; // [R15]

// ten-bit decode aliases across every 1KB of the first 64KB; sixteen-bit does not
assign vga_io_hit = io_first_64k && vga_io_low10 &&
                    (!ctl_vga16 ||
                     (req_addr[15:10] == `BWC_VGA16_HI_ZERO)); // [R17]

// ----------------------------------------
// next decisions
// ----------------------------------------
// memory and io requests share only the vga decision
reg         next_prefetch_hit;
reg         next_io_down;
reg         next_io_up;
reg         next_vga;

always @* begin
  next_prefetch_hit = 1'b0;
  next_io_down      = 1'b0;
  next_io_up        = 1'b0;
  next_vga          = 1'b0;
  if (req_valid) begin
    if (req_is_io) begin
      if (ctl_isa) begin
        next_io_up   = isa_up; // [R12]
        next_io_down = io_in_win && !isa_up; // [R12]
      end else begin
        next_io_down = io_in_win; // [R11]
      end
      next_vga = ctl_vga && vga_io_hit; // [R13]
    end else begin
      next_prefetch_hit = pf_in_win; // [R18]
      next_vga          = ctl_vga && vga_mem_hit; // [R13]
    end
  end
end

// ----------------------------------------
// registered outputs
// ----------------------------------------
// one cycle of latency keeps every output straight off a flop
always @(posedge clock or posedge rst) begin
  if (rst) begin
    decide_valid      <= 1'b0;
    prefetch_hit      <= 1'b0;
    io_forward_down   <= 1'b0;
    io_forward_up     <= 1'b0;
    vga_forward       <= 1'b0;
    poison_report     <= 1'b0;
    error_msg_forward <= 1'b0;
  end else begin
    decide_valid      <= req_valid;
    prefetch_hit      <= next_prefetch_hit;
    io_forward_down   <= next_io_down; // [R11]
    io_forward_up     <= next_io_up; // [R12]
    vga_forward       <= next_vga; // [R13]
    poison_report     <= sec_poison_seen && ctl_poison; // [R09]
    error_msg_forward <= sec_error_msg && ctl_err_fwd; // [R10]
  end
end

// ----------------------------------------
// control levels
// ----------------------------------------
// copies lag the stored bits by one cycle
always @(posedge clock or posedge rst) begin
  if (rst) begin
    poison_response_enable         <= 1'b0;
    secondary_error_forward_enable <= 1'b0;
    isa_enable                     <= 1'b0;
    vga_enable                     <= 1'b0;
    vga_16bit_decode               <= 1'b0;
    interrupt_pin                  <= `BWC_RST_8;
  end else begin
    poison_response_enable         <= ctl_poison; // [R09]
    secondary_error_forward_enable <= ctl_err_fwd; // [R10]
    isa_enable                     <= ctl_isa;
    vga_enable                     <= ctl_vga;
    vga_16bit_decode               <= ctl_vga16;
    interrupt_pin                  <= interrupt_pin_byte;
  end
end

endmodule

// file: bench/bwc_chk.sv
`timescale 1ns/100ps
// ------
// bridge header checker
// ------
module bwc_chk (
  // clock and reset
  input wire        clock,
  input wire        rst,
  // register port
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  // requests and events
  input wire        req_valid,
  input wire        req_is_io,
  input wire        sec_poison_seen,
  input wire        sec_error_msg,
  input wire [63:0] req_addr,
  // decisions and control levels
  input wire        decide_valid,
  input wire        prefetch_hit,
  input wire        io_forward_down,
  input wire        io_forward_up,
  input wire        vga_forward,
  input wire        poison_report,
  input wire        error_msg_forward,
  input wire        vga_enable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // control word write, then one edge for the register to land
  sequence ctrl_wr_s;
    reg_wr && reg_addr == 8'h3c ##1 1'b1;
  endsequence
  sequence isa_up_s;
    req_valid && req_is_io ##1 io_forward_up;
  endsequence
  cap_read_a: assert property (reg_rd && reg_addr == 8'h34 |=> reg_rdata == 32'h40)
    else $error("capability pointer read wrong");
  vga_ctrl_a: assert property (ctrl_wr_s |=> vga_enable == $past(reg_wdata[19], 2))
    else $error("vga enable does not follow the write");
  idle_out_a: assert property (!req_valid |=> !decide_valid && !prefetch_hit)
    else $error("decision without a request");
  isa_up_a: assert property (isa_up_s |-> !io_forward_down
      && $past(req_addr[31:16]) == 16'h0 && $past(req_addr[9:8]) != 2'h0)
    else $error("upstream io outside the top of a block");
  vga_mem_a: assert property (vga_forward && !$past(req_is_io)
      |-> $past(req_addr) inside {[64'ha0000:64'hbffff]})
    else $error("vga memory forward outside range");
  vga_io_a: assert property (vga_forward && $past(req_is_io)
      |-> $past(req_addr[9:0]) inside {[10'h3b0:10'h3bb], [10'h3c0:10'h3df]})
    else $error("vga io forward outside range");
  poison_a: assert property (poison_report |-> $past(sec_poison_seen))
    else $error("poison report without a poisoned packet");
  err_fwd_a: assert property (error_msg_forward |-> $past(sec_error_msg))
    else $error("error message forward without a message");
endmodule

bind bwc_top bwc_chk u_chk (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .req_valid(req_valid),
  .req_is_io(req_is_io), .sec_poison_seen(sec_poison_seen), .sec_error_msg(sec_error_msg),
  .req_addr(req_addr), .decide_valid(decide_valid), .prefetch_hit(prefetch_hit),
  .io_forward_down(io_forward_down), .io_forward_up(io_forward_up),
  .vga_forward(vga_forward), .poison_report(poison_report),
  .error_msg_forward(error_msg_forward), .vga_enable(vga_enable));

// file: bench/bwc_fwd_model.sv
`timescale 1ns/100ps
// ------
// forwarding-side requester
// ------
module bwc_fwd_model (
  // clock
  input  wire        clock,
  // request to classify
  output reg         req_valid = 1'b0,
  output reg         req_is_io = 1'b0,
  output reg  [63:0] req_addr = 64'h0
);
  // idle address is the inverse of the last, so a stale decode never matches by luck
  task send(input logic io, input logic [63:0] a);
    @(posedge clock);
    req_valid <= 1'b1;
    req_is_io <= io;
    req_addr <= a;
    @(posedge clock);
    req_valid <= 1'b0;
    req_addr <= ~a;
    #1;
  endtask
endmodule

// file: bench/test_bridge_window_config_header.sv
`timescale 1ns/100ps
// ------
// bench top
// ------
module test_bridge_window_config_header;
  reg         clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  reg         sideband_pin_we = 1'b0, eeprom_pin_we = 1'b0;
  reg         sec_poison_seen = 1'b0, sec_error_msg = 1'b0;
  reg  [7:0]  reg_addr = 8'h0, sideband_pin_data = 8'h0, eeprom_pin_data = 8'h0;
  reg  [31:0] reg_wdata = 32'h0;
  reg  [11:0] pf_base_low = 12'h010, pf_limit_low = 12'h020;
  reg  [3:0]  io_base_low = 4'h1, io_limit_low = 4'h2;
  wire        req_valid, req_is_io, decide_valid, prefetch_hit, io_forward_down;
  wire        io_forward_up, vga_forward, poison_report, error_msg_forward;
  wire        poison_response_enable, secondary_error_forward_enable, isa_enable;
  wire        vga_enable, vga_16bit_decode;
  wire [63:0] req_addr;
  wire [31:0] reg_rdata;
  wire [7:0]  interrupt_pin;
  wire [31:0] ctrl_bits = {27'h0, vga_16bit_decode, vga_enable, isa_enable,
                           secondary_error_forward_enable, poison_response_enable};
  wire [31:0] dec_bits = {27'h0, decide_valid, prefetch_hit, io_forward_down,
                          io_forward_up, vga_forward};
  integer     error_cnt = 0;
  integer     comparisons = 0;

  bwc_top #(
    .DOWNSTREAM(1)
  ) uut (
    .clock                          (clock),
    .rst                            (rst),
    .reg_addr                       (reg_addr),
    .reg_wdata                      (reg_wdata),
    .reg_wr                         (reg_wr),
    .reg_rd                         (reg_rd),
    .reg_rdata                      (reg_rdata),
    .pf_base_low                    (pf_base_low),
    .pf_limit_low                   (pf_limit_low),
    .io_base_low                    (io_base_low),
    .io_limit_low                   (io_limit_low),
    .sideband_pin_we                (sideband_pin_we),
    .sideband_pin_data              (sideband_pin_data),
    .eeprom_pin_we                  (eeprom_pin_we),
    .eeprom_pin_data                (eeprom_pin_data),
    .req_valid                      (req_valid),
    .req_is_io                      (req_is_io),
    .req_addr                       (req_addr),
    .sec_poison_seen                (sec_poison_seen),
    .sec_error_msg                  (sec_error_msg),
    .decide_valid                   (decide_valid),
    .prefetch_hit                   (prefetch_hit),
    .io_forward_down                (io_forward_down),
    .io_forward_up                  (io_forward_up),
    .vga_forward                    (vga_forward),
    .poison_report                  (poison_report),
    .error_msg_forward              (error_msg_forward),
    .poison_response_enable         (poison_response_enable),
    .secondary_error_forward_enable (secondary_error_forward_enable),
    .isa_enable                     (isa_enable),
    .vga_enable                     (vga_enable),
    .vga_16bit_decode               (vga_16bit_decode),
    .interrupt_pin                  (interrupt_pin)
  );
  bwc_fwd_model pm (.clock(clock), .req_valid(req_valid), .req_is_io(req_is_io),
    .req_addr(req_addr));

  initial begin
    forever #10 clock = ~clock;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd_exp(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task req_exp(input logic io, input logic [63:0] a, input logic [3:0] e);
    pm.send(io, a);
    chk(dec_bits, {27'h0, 1'b1, e});
  endtask
  // sideband data and eeprom data differ so the winner is visible
  task pin_exp(input logic sb, input logic ee, input logic [7:0] e);
    @(posedge clock);
    {sideband_pin_we, eeprom_pin_we} <= {sb, ee};
    sideband_pin_data <= sb ? e : ~e;
    eeprom_pin_data <= sb ? ~e : e;
    @(posedge clock);
    {sideband_pin_we, eeprom_pin_we} <= 2'b00;
    repeat (2) @(posedge clock);
    #1;
    chk({24'h0, interrupt_pin}, {24'h0, e});
  endtask
  task ev_exp(input logic [1:0] ev, input logic [31:0] e);
    @(posedge clock);
    {sec_poison_seen, sec_error_msg} <= ev;
    @(posedge clock);
    {sec_poison_seen, sec_error_msg} <= 2'b00;
    #1;
    chk({30'h0, poison_report, error_msg_forward}, e);
  endtask

  task t_regs;
    chk(ctrl_bits, 32'h0);
    rd_exp(8'h3c, 32'h0);
    rd_exp(8'h28, 32'h0);
    wr(8'h28, 32'ha5a5_5a5a);
    wr(8'h2c, 32'h1234_5678);
    wr(8'h30, 32'hbeef_cafe);
    wr(8'h34, 32'hffff_ffff);
    wr(8'h3c, 32'hffff_ffff);
    rd_exp(8'h28, 32'ha5a5_5a5a);
    rd_exp(8'h2c, 32'h1234_5678);
    rd_exp(8'h30, 32'hbeef_cafe);
    rd_exp(8'h34, 32'h0000_0040);
    rd_exp(8'h3c, 32'h001f_00ff);
    chk(ctrl_bits, 32'h1f);
  endtask
  task t_pin_events;
    pin_exp(1'b1, 1'b1, 8'h02);
    pin_exp(1'b0, 1'b1, 8'h04);
    wr(8'h3c, 32'h0);
    rd_exp(8'h3c, 32'h0400);
    ev_exp(2'b11, 32'h0);
    wr(8'h3c, 32'h0003_0000);
    ev_exp(2'b11, 32'h3);
    ev_exp(2'b01, 32'h1);
  endtask
  task t_window;
    wr(8'h28, 32'h1);
    wr(8'h2c, 32'h1);
    wr(8'h30, 32'h0);
    wr(8'h3c, 32'h0);
    req_exp(1'b0, {32'h1, 12'h010, 20'h0}, 4'b1000);
    req_exp(1'b0, {32'h1, 12'h00f, 20'hfffff}, 4'b0000);
    req_exp(1'b0, {32'h1, 12'h020, 20'hfffff}, 4'b1000);
    req_exp(1'b0, {32'h1, 12'h021, 20'h0}, 4'b0000);
    req_exp(1'b0, {32'h0, 12'h010, 20'h0}, 4'b0000);
    req_exp(1'b1, 64'h1000, 4'b0100);
    req_exp(1'b1, 64'h3000, 4'b0000);
    wr(8'h3c, 32'h0004_0000);
    req_exp(1'b1, 64'h1100, 4'b0010);
    req_exp(1'b1, 64'h2000, 4'b0100);
    wr(8'h30, 32'h0001_0001);
    req_exp(1'b1, 64'h11100, 4'b0100);
  endtask
  task t_vga;
    wr(8'h30, 32'h0);
    wr(8'h3c, 32'h0008_0000);
    req_exp(1'b0, 64'ha0000, 4'b0001);
    req_exp(1'b0, 64'hc0000, 4'b0000);
    req_exp(1'b1, 64'h3bb, 4'b0001);
    req_exp(1'b1, 64'h3bc, 4'b0000);
    req_exp(1'b1, 64'h3df, 4'b0001);
    req_exp(1'b1, 64'h103c0, 4'b0000);
    req_exp(1'b1, 64'h13c0, 4'b0101);
    wr(8'h3c, 32'h0018_0000);
    req_exp(1'b1, 64'h13c0, 4'b0100);
    req_exp(1'b1, 64'h3c0, 4'b0001);
    wr(8'h3c, 32'h0);
    req_exp(1'b0, 64'hb0000, 4'b0000);
  endtask

  task stop_test;
    $display("mismatches %0d of %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_pin_events;
    t_window;
    t_vga;
    stop_test;
  end
  // guard against a hang
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt = error_cnt + 1;
    stop_test;
  end
endmodule
